// ==== dv/i2c_master_model.sv ====
`timescale 1ns/1ps
// -------------------------------
// two-wire master, 30 ns bit slot
// -------------------------------
module i2c_master_model
(
  output logic      scl,     // link clock
  output logic      drv_low, // master pulls data low
  input  wire logic sda      // resolved data line
);
  // idle bus: clock stands high, data released
  initial
  begin
    scl = 1'b1;
    drv_low = 1'b0;
  end

  // start, then clock held low while the device settles
  task automatic start();
    drv_low = 1'b1;
    #300; // start hold before the clock falls
    scl = 1'b0;
    #600;
  endtask

  // data changes only while the clock is low
  task automatic slot(input logic b, output logic r);
    #7;
    drv_low = ~b;
    #8;
    scl = 1'b1;
    r = sda;
    #15;
    scl = 1'b0;
  endtask

  // eight bits msb first, then the ack slot
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic nak);
    for (int i = 7; i >= 0; i--)
      slot(d[i], q[i]);
    slot(last, nak);
  endtask

  // stop, then the clock stands still
  task automatic stop();
    #7;
    drv_low = 1'b1;
    #8;
    scl = 1'b1;
    #15;
    drv_low = 1'b0;
    #1000;
  endtask
endmodule // i2c_master_model

// ==== dv/temp_sensor_alarm_logic_bench.sv ====
`timescale 1ns/1ps
module temp_sensor_alarm_logic_bench;
  import temp_alarm_pkg::*;
  logic        mclk, rst, scl, drv_low, sda, sda_out, sda_oe, alarm_out, a, alarm_active_level;
  logic [2:0]  straps;
  logic [5:0]  nv;
  logic [11:0] sensor_code, c, hot, cold;
  logic [15:0] w;
  logic [7:0]  q8;
  logic [7:0]  adr [4];
  logic [31:0] rnd;
  int          seed = 66;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;

  // open-drain line with pull-up
  assign sda = (sda_oe ? sda_out : 1'b1) & ~drv_low;

  i2c_master_model i_m (.scl(scl), .drv_low(drv_low), .sda(sda));

  temp_sensor_alarm_logic #(.CONV9_CYC(8)) i_dut (
    .mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_select_pin_2(straps[2]), .addr_select_pin_1(straps[1]),
    .addr_select_pin_0(straps[0]), .stored_resolution_hi(nv[5]),
    .stored_resolution_lo(nv[4]), .stored_queue_sel_hi(nv[3]), .stored_queue_sel_lo(nv[2]),
    .stored_active_level(nv[1]), .stored_behaviour_select(nv[0]),
    .sensor_code(sensor_code), .alarm_out(alarm_out));

  // core clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // -------------------
  // checks and verdict
  // -------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  // -------------------
  // link and stimulus
  // -------------------
  task automatic pause(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr_reg(input logic [1:0] p, input int n, input logic [15:0] d);
    logic [7:0] q;
    i_m.start();
    i_m.xfer({TYPE_SENSOR, straps, 1'b0}, 1'b1, q, a);
    chk("addr ack", 16'h0, {15'h0, a});
    i_m.xfer({6'h0, p}, 1'b1, q, a);
    if (n > 0)
      i_m.xfer(d[15:8], 1'b1, q, a);
    if (n > 1)
      i_m.xfer(d[7:0], 1'b1, q, a);
    i_m.stop();
  endtask

  task automatic rd_reg(input logic [1:0] p, output logic [15:0] r);
    wr_reg(p, 0, 16'h0);
    i_m.start();
    i_m.xfer({TYPE_SENSOR, straps, 1'b1}, 1'b1, r[15:8], a);
    i_m.xfer(8'hff, 1'b0, r[15:8], a);
    i_m.xfer(8'hff, 1'b1, r[7:0], a);
    i_m.stop();
  endtask

  // new sample, wait, then look at the alarm pin
  task automatic run(input logic [11:0] v, input int n, input logic lvl);
    @(posedge mclk);
    sensor_code <= v;
    pause(n);
    chk("alarm", {15'h0, lvl}, {15'h0, alarm_out});
  endtask

  // main sequence
  initial
  begin
    rnd = $random(seed);
    straps = rnd[2:0];
    nv = rnd[8:3];
    alarm_active_level = rnd[9];
    hot = 12'h190 + {3'h0, rnd[18:10]};
    cold = {4'h0, rnd[26:19] & 8'h9f};
    sensor_code = 12'h100;
    rst = 1'b1;
    pause(8);
    rst <= 1'b0;
    pause(20);
    chk("alarm idle", {15'h0, ~nv[1]}, {15'h0, alarm_out});
    rd_reg(PTR_CFG, w);
    chk("cfg", {1'b0, nv, 1'b0, 8'h00}, w);
    adr = '{{TYPE_SENSOR, straps, 1'b0}, {TYPE_STORE, straps, 1'b1},
            {4'h6, straps, 1'b0}, {TYPE_SENSOR, ~straps, 1'b0}};
    for (int k = 0; k < 4; k++)
    begin
      i_m.start();
      i_m.xfer(adr[k], 1'b1, q8, a);
      chk("addr", {15'h0, (k > 1)}, {15'h0, a});
      if (k == 1)
      begin
        i_m.xfer(8'hff, 1'b1, q8, a);
        chk("store", 16'h00ff, {8'h0, q8});
      end
      i_m.stop();
    end
    wr_reg(PTR_THIGH, 2, 16'h1900);
    wr_reg(PTR_TLOW, 2, 16'h0a00);
    rd_reg(PTR_THIGH, w);
    chk("thigh", 16'h1900, w);
    for (int r = 0; r < 4; r++)
    begin
      wr_reg(PTR_CFG, 1, {1'b0, 2'(r), 2'h0, alarm_active_level, 2'h0, 8'h0});
      rnd = $random(seed);
      c = 12'h0a8 + {4'h0, rnd[7:0] & 8'hdf};
      run(c, 150, ~alarm_active_level);
      rd_reg(PTR_TEMP, w);
      chk("temp", {c & (RES_FULL << (RES_MAX - 2'(r))), 4'h0}, w);
    end
    // comparator, six faults, nine-bit results
    wr_reg(PTR_CFG, 1, {1'b0, 2'h0, 2'h3, alarm_active_level, 2'h0, 8'h0});
    run(hot, 36, ~alarm_active_level);
    run(12'h100, 24, ~alarm_active_level);
    run(hot, 36, ~alarm_active_level);
    run(hot, 64, alarm_active_level);
    rd_reg(PTR_TEMP, w);
    chk("alarm kept", {15'h0, alarm_active_level}, {15'h0, alarm_out});
    run(12'h100, 24, alarm_active_level);
    run(cold, 36, alarm_active_level);
    run(cold, 64, ~alarm_active_level);
    // interrupt, single fault
    wr_reg(PTR_CFG, 1, {1'b0, 2'h0, 2'h0, alarm_active_level, 2'h2, 8'h0});
    run(cold, 40, ~alarm_active_level);
    run(hot, 40, alarm_active_level);
    rd_reg(PTR_TEMP, w);
    run(hot, 40, ~alarm_active_level);
    run(cold, 40, alarm_active_level);
    rd_reg(PTR_TEMP, w);
    run(cold, 40, ~alarm_active_level);
    tally_and_finish();
  end
endmodule // temp_sensor_alarm_logic_bench

// ==== rtl/link_if.sv ====
`timescale 1ns/1ps
interface link_if;
  logic        hold;    // link held idle
  logic [2:0]  addr;    // strapped address bits
  logic [15:0] rd_word; // frozen read word
  logic [1:0]  ptr;     // register pointer
  logic        wr_tog;  // toggles per written byte
  logic        wr_idx;  // byte index of that write
  logic [7:0]  wr_data; // written byte
  logic        rd_tog;  // toggles per read address
  modport core (output hold, addr, rd_word, input ptr, wr_tog, wr_idx, wr_data, rd_tog);
  modport link (input hold, addr, rd_word, output ptr, wr_tog, wr_idx, wr_data, rd_tog);
endinterface

// ==== rtl/serial_link.sv ====
`timescale 1ns/1ps
module serial_link
  import temp_alarm_pkg::*;
(
  input  wire logic rst,     // async reset
  input  wire logic scl,     // link clock
  input  wire logic sda_in,  // data line level
  output logic      sda_out, // data drive level
  output logic      sda_oe,  // data drive enable
  link_if.link      lk       // core side
);
  link_st_t   st, next_st;
  logic [3:0] bitc, next_bitc;
  logic [6:0] sh, next_sh;
  logic       ack, next_ack, stor, next_stor, ridx, next_ridx, wseen, next_wseen;
  logic [1:0] next_ptr;
  logic       next_wr_tog, next_wr_idx, next_rd_tog, next_oe;
  logic [7:0] next_wr_data, byte_in, rd_byte;
  logic       lrst;

  assign lrst    = rst | lk.hold;
  assign byte_in = {sh, sda_in};

  // byte framing on the rising edge
  always_comb
  begin
    next_st = st;
    next_bitc = 4'(bitc + 4'h1);
    next_sh = {sh[5:0], sda_in};
    next_ack = ack;
    next_stor = stor;
    next_ridx = ridx;
    next_wseen = wseen;
    next_ptr = lk.ptr;
    next_wr_tog = lk.wr_tog;
    next_wr_idx = lk.wr_idx;
    next_wr_data = lk.wr_data;
    next_rd_tog = lk.rd_tog;
    if (bitc == ACK_BIT)
    begin
      next_bitc = '0;
      next_ack = 1'b0;
      if (st == L_RD)
      begin
        if (!ack)
          next_ridx = ~ridx; // address ack keeps the high byte first
        if (sda_in)
          next_st = L_IGN;
      end
    end
    else if (bitc == LAST_BIT)
    begin
      next_ack = 1'b1;
      case (st)
        L_ADDR:
        begin
          if ((byte_in[7:4] == TYPE_SENSOR || byte_in[7:4] == TYPE_STORE)
              && byte_in[3:1] == lk.addr)
          begin
            next_stor = (byte_in[7:4] == TYPE_STORE);
            next_st = byte_in[0] ? L_RD : L_PTR;
            if (byte_in[0])
              next_rd_tog = ~lk.rd_tog;
          end
          else
          begin
            next_ack = 1'b0;
            next_st = L_IGN;
          end
        end
        L_PTR:
        begin
          if (!stor)
            next_ptr = byte_in[1:0];
          next_st = L_WDAT;
        end
        L_WDAT:
        begin
          if (!stor)
          begin
            next_wr_tog = ~lk.wr_tog;
            next_wr_idx = wseen;
            next_wr_data = byte_in;
          end
          next_wseen = 1'b1;
        end
        default: next_ack = 1'b0;
      endcase
    end
  end

  always_ff @(posedge scl or posedge lrst)
  begin
    if (lrst)
    begin
      st <= L_ADDR;
      bitc <= '0;
      sh <= '0;
      ack <= 1'b0;
      stor <= 1'b0;
      ridx <= 1'b0;
      wseen <= 1'b0;
    end
    else
    begin
      st <= next_st;
      bitc <= next_bitc;
      sh <= next_sh;
      ack <= next_ack;
      stor <= next_stor;
      ridx <= next_ridx;
      wseen <= next_wseen;
    end
  end

  // pointer and write handoff survive frame ends
  always_ff @(posedge scl or posedge rst)
  begin
    if (rst)
    begin
      lk.ptr <= PTR_TEMP;
      lk.wr_tog <= 1'b0;
      lk.wr_idx <= 1'b0;
      lk.wr_data <= '0;
      lk.rd_tog <= 1'b0;
    end
    else
    begin
      lk.ptr <= next_ptr;
      lk.wr_tog <= next_wr_tog;
      lk.wr_idx <= next_wr_idx;
      lk.wr_data <= next_wr_data;
      lk.rd_tog <= next_rd_tog;
    end
  end

  // drive on the falling edge: ack or read data
  always_comb
  begin
    rd_byte = stor ? IDLE_BYTE : (ridx ? lk.rd_word[7:0] : lk.rd_word[15:8]);
    if (bitc == ACK_BIT)
      next_oe = ack;
    else if (st == L_RD)
      next_oe = ~rd_byte[3'(LAST_BIT - bitc)];
    else
      next_oe = 1'b0;
  end

  always_ff @(negedge scl or posedge lrst)
  begin
    if (lrst)
    begin
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      sda_oe <= next_oe;
      sda_out <= 1'b0;
    end
  end
endmodule // serial_link

// ==== rtl/temp_alarm_pkg.sv ====
package temp_alarm_pkg;
  // address type nibbles
  localparam logic [3:0] TYPE_SENSOR = 4'h9;
  localparam logic [3:0] TYPE_STORE  = 4'ha;
  // register pointers
  localparam logic [1:0] PTR_TEMP  = 2'h0;
  localparam logic [1:0] PTR_CFG   = 2'h1;
  localparam logic [1:0] PTR_TLOW  = 2'h2;
  localparam logic [1:0] PTR_THIGH = 2'h3;
  // configuration byte layout
  localparam int CFG_RES  = 5;
  localparam int CFG_FQ   = 3;
  localparam int CFG_POL  = 2;
  localparam int CFG_MODE = 1;
  // result and limit format
  localparam int         TEMP_W    = 12;
  localparam int         FRAC_W    = 4;
  localparam logic [11:0] RES_FULL = 12'hfff;
  localparam logic [1:0]  RES_MAX  = 2'h3;
  localparam logic [11:0] TLOW_RST  = 12'h4b0;
  localparam logic [11:0] THIGH_RST = 12'h500;
  localparam logic [7:0]  IDLE_BYTE = 8'hff;
  // link bit positions
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT  = 4'h8;
  // timing
  localparam int CLK_MHZ  = 20;
  localparam int CONV9_US = 25;
  localparam int CNT_W    = 12;
  // synchroniser lanes and idle levels
  localparam int         NSYNC    = 8;
  localparam int         SY_RD    = 0;
  localparam int         SY_WR    = 1;
  localparam int         SY_START = 2;
  localparam int         SY_SCL   = 3;
  localparam int         SY_ADDR  = 4;
  localparam int         SY_STOP  = 7;
  localparam logic [7:0] SYNC_RST = 8'h08;
  localparam logic       ALARM_IDLE = 1'b1;
  localparam logic [2:0] FCOUNT_MAX = 3'h7;

  typedef enum logic [4:0] {
    L_ADDR = 5'h01, L_PTR = 5'h02, L_WDAT = 5'h04, L_RD = 5'h08, L_IGN = 5'h10
  } link_st_t;

  typedef enum logic [2:0] {F_IDLE = 3'h1, F_START = 3'h2, F_RUN = 3'h4} frame_st_t;

  // consecutive faults needed per queue setting
  function automatic logic [2:0] fq_need(input logic [1:0] sel);
    case (sel)
      2'h0:    fq_need = 3'h1;
      2'h1:    fq_need = 3'h2;
      2'h2:    fq_need = 3'h4;
      default: fq_need = 3'h6;
    endcase
  endfunction
endpackage

// ==== rtl/temp_sensor_alarm_logic.sv ====
`timescale 1ns/1ps
// How it works
// - answer sensor or storage type, strap bits
// - address byte ends in direction bit
// - ack on match, else release and idle
// - convert continuously, overwrite result each time
// - result readable at any time
// - two bits pick 9 to 12 result bits
// - conversion lengthens with each resolution bit
// - resolution loads from stored copy at reset
// - 12-bit result spans -128 to +127
// - each new result checked against both limits
// - polarity bit sets alarm active level
// - mode bit picks comparator or interrupt
// - polarity and mode load from stored copies
// - fault when at/over high or at/under low
// - queue needs one, two, four, six faults
// - counter increments, valid fault at queue count
// - non-fault result clears the fault counter
// - queue setting loads from stored copy
// - comparator sets high, clears on low fault
// - interrupt holds until read, alternates high/low
module temp_sensor_alarm_logic
  import temp_alarm_pkg::*;
#(
  parameter int CONV9_CYC = CONV9_US * CLK_MHZ // cycles of a 9-bit conversion
)
(
  input  wire logic        mclk,                    // core clock
  input  wire logic        rst,                     // async reset, high
  input  wire logic        scl,                     // link clock from master
  input  wire logic        sda_in,                  // data line level
  output logic             sda_out,                 // data drive level
  output logic             sda_oe,                  // data drive enable
  input  wire logic        addr_select_pin_2,       // address strap
  input  wire logic        addr_select_pin_1,       // address strap
  input  wire logic        addr_select_pin_0,       // address strap
  input  wire logic        stored_resolution_hi,    // stored resolution
  input  wire logic        stored_resolution_lo,    // stored resolution
  input  wire logic        stored_active_level,     // stored polarity
  input  wire logic        stored_behaviour_select, // stored mode
  input  wire logic        stored_queue_sel_hi,     // stored queue
  input  wire logic        stored_queue_sel_lo,     // stored queue
  input  wire logic [11:0] sensor_code,             // converter sample
  output logic             alarm_out                // alarm pin level
);
  link_if lk ();

  // ----------------------------------------------------------------
  // link logic
  // ----------------------------------------------------------------
  serial_link u_link (
    .rst     (rst),
    .scl     (scl),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .lk      (lk.link)
  );

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic [NSYNC-1:0] raw, stab, prev;
  logic             scl_s, start_tog, stop_tog, start, stop, wr_ev, rd_ev;

  // start: data falls while the clock is high; the link clock is too fast to oversample
  always_ff @(negedge sda_in or posedge rst)
  begin
    if (rst)
      start_tog <= 1'b0;
    else if (scl)
      start_tog <= ~start_tog;
  end

  // stop: data rises while the clock is high
  always_ff @(posedge sda_in or posedge rst)
  begin
    if (rst)
      stop_tog <= 1'b0;
    else if (scl)
      stop_tog <= ~stop_tog;
  end

  assign raw = {stop_tog, addr_select_pin_2, addr_select_pin_1, addr_select_pin_0,
                scl, start_tog, lk.wr_tog, lk.rd_tog};

  // three flops, change taken once second and third agree
  for (genvar i = 0; i < NSYNC; i++)
  begin : g_sync
    logic [2:0] sr;
    logic       q;
    always_ff @(posedge mclk or posedge rst)
    begin
      if (rst)
      begin
        sr <= {3{SYNC_RST[i]}};
        q <= SYNC_RST[i];
      end
      else
      begin
        sr <= {sr[1:0], raw[i]};
        if (sr[1] == sr[2])
          q <= sr[2];
      end
    end
    assign stab[i] = q;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      prev <= SYNC_RST;
    else
      prev <= stab;
  end

  // bus conditions and handoff events
  assign scl_s = stab[SY_SCL];
  assign start = stab[SY_START] ^ prev[SY_START];
  assign stop  = stab[SY_STOP] ^ prev[SY_STOP];
  assign wr_ev = stab[SY_WR] ^ prev[SY_WR];
  assign rd_ev = stab[SY_RD] ^ prev[SY_RD];

  // ----------------------------------------------------------------
  // frame tracking and read snapshot
  // ----------------------------------------------------------------
  frame_st_t   fs, next_fs;
  logic        next_hold;
  logic [2:0]  next_addr;
  logic [15:0] next_rd_word;
  logic [1:0]  res, next_res, fq, next_fq;
  logic        alarm_active_level, next_pol, mode, next_mode, loaded, next_loaded;
  logic [11:0] temp, next_temp, tlow, next_tlow, thigh, next_thigh;

  // link held idle until a start, released once clock is low
  always_comb
  begin
    next_fs = fs;
    case (fs)
      F_IDLE:  next_fs = F_IDLE;
      F_START: if (!scl_s) next_fs = F_RUN;
      F_RUN:   next_fs = F_RUN;
      default: next_fs = F_IDLE;
    endcase
    if (start)
      next_fs = F_START;
    else if (stop)
      next_fs = F_IDLE;
    next_hold = (next_fs != F_RUN);
    next_addr = stab[SY_ADDR +: 3];
    next_rd_word = lk.rd_word;
    if (lk.hold)
    begin
      case (lk.ptr)
        PTR_TEMP:  next_rd_word = {temp, {FRAC_W{1'b0}}};
        PTR_CFG:   next_rd_word = {1'b0, res, fq, alarm_active_level, mode, 1'b0, 8'h00};
        PTR_TLOW:  next_rd_word = {tlow, {FRAC_W{1'b0}}};
        default:   next_rd_word = {thigh, {FRAC_W{1'b0}}};
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fs <= F_IDLE;
      lk.hold <= 1'b1;
      lk.addr <= '0;
      lk.rd_word <= '0;
    end
    else
    begin
      fs <= next_fs;
      lk.hold <= next_hold;
      lk.addr <= next_addr;
      lk.rd_word <= next_rd_word;
    end
  end

  // ----------------------------------------------------------------
  // configuration and limits
  // ----------------------------------------------------------------
  always_comb
  begin
    next_loaded = 1'b1;
    next_res = res;
    next_fq = fq;
    next_pol = alarm_active_level;
    next_mode = mode;
    next_tlow = tlow;
    next_thigh = thigh;
    if (!loaded)
    begin
      next_res = {stored_resolution_hi, stored_resolution_lo};
      next_pol = stored_active_level;
      next_mode = stored_behaviour_select;
      next_fq = {stored_queue_sel_hi, stored_queue_sel_lo};
    end
    else if (wr_ev)
    begin
      case (lk.ptr)
        PTR_CFG:
        begin
          if (!lk.wr_idx)
          begin
            next_res = lk.wr_data[CFG_RES +: 2];
            next_fq = lk.wr_data[CFG_FQ +: 2];
            next_pol = lk.wr_data[CFG_POL];
            next_mode = lk.wr_data[CFG_MODE];
          end
        end
        PTR_TLOW:
        begin
          if (lk.wr_idx)
            next_tlow = {tlow[TEMP_W-1 -: 8], lk.wr_data[7 -: FRAC_W]};
          else
            next_tlow = {lk.wr_data, tlow[FRAC_W-1:0]};
        end
        PTR_THIGH:
        begin
          if (lk.wr_idx)
            next_thigh = {thigh[TEMP_W-1 -: 8], lk.wr_data[7 -: FRAC_W]};
          else
            next_thigh = {lk.wr_data, thigh[FRAC_W-1:0]};
        end
        default: next_res = res;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      loaded <= 1'b0;
      res <= '0;
      fq <= '0;
      alarm_active_level <= 1'b0;
      mode <= 1'b0;
      tlow <= TLOW_RST;
      thigh <= THIGH_RST;
    end
    else
    begin
      loaded <= next_loaded;
      res <= next_res;
      fq <= next_fq;
      alarm_active_level <= next_pol;
      mode <= next_mode;
      tlow <= next_tlow;
      thigh <= next_thigh;
    end
  end

  // ----------------------------------------------------------------
  // continuous conversion
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt, next_cnt, conv_len;
  logic [11:0]      res_mask;
  logic             fresh, next_fresh;

  assign conv_len = CNT_W'(CONV9_CYC) << res;
  assign res_mask = RES_FULL << (RES_MAX - res);

  // store a masked two's complement sample at each count end
  always_comb
  begin
    next_cnt = CNT_W'(cnt - 1'b1);
    next_temp = temp;
    next_fresh = 1'b0;
    if (cnt == '0)
    begin
      next_temp = sensor_code & res_mask;
      next_fresh = 1'b1;
      next_cnt = CNT_W'(conv_len - 1'b1);
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= '0;
      temp <= '0;
      fresh <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      temp <= next_temp;
      fresh <= next_fresh;
    end
  end

  // ----------------------------------------------------------------
  // fault queue and alarm
  // ----------------------------------------------------------------
  logic [2:0] fcount, next_fcount, need;
  logic       act, next_act, exp_hi, next_exp_hi, next_alarm;
  logic       hi, lo, fault, valid;

  assign hi    = $signed(temp) >= $signed(thigh);
  assign lo    = $signed(temp) <= $signed(tlow);
  assign fault = hi | lo;
  assign need  = fq_need(fq);

  always_comb
  begin
    next_fcount = fcount;
    next_act = act;
    next_exp_hi = exp_hi;
    valid = 1'b0;
    if (mode && rd_ev)
      next_act = 1'b0;
    if (fresh)
    begin
      if (!fault)
        next_fcount = '0;
      else if (fcount != FCOUNT_MAX)
        next_fcount = 3'(fcount + 3'h1);
      valid = fault && (next_fcount >= need);
      if (!mode)
      begin
        if (!act && valid && hi)
          next_act = 1'b1;
        else if (act && valid && lo && !hi)
          next_act = 1'b0;
        next_exp_hi = ~next_act;
      end
      else if (valid && (exp_hi ? hi : lo))
      begin
        next_act = 1'b1;
        next_exp_hi = ~exp_hi;
      end
    end
    next_alarm = next_act ~^ next_pol;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fcount <= '0;
      act <= 1'b0;
      exp_hi <= 1'b1;
      alarm_out <= ALARM_IDLE;
    end
    else
    begin
      fcount <= next_fcount;
      act <= next_act;
      exp_hi <= next_exp_hi;
      alarm_out <= next_alarm;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [CNT_W:0] gap;

  // cycles since the previous stored result
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      gap <= '0;
    else
      gap <= fresh ? (CNT_W+1)'(1) : (CNT_W+1)'(gap + 1'b1);
  end

  logic [CNT_W:0] len_seen;
  logic           primed;

  // length of the running conversion, and whether one has ended yet
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      len_seen <= '0;
      primed <= 1'b0;
    end
    else
    begin
      if (cnt == '0)
        len_seen <= (CNT_W+1)'(CONV9_CYC) << res;
      if (fresh)
        primed <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_hold_start;
    start |=> lk.hold ##1 lk.hold;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("link not held after start");

  property p_conv_len;
    fresh && $past(fresh) == 1'b0 && $stable(res) && gap == (CNT_W+1)'(conv_len)
      |-> 1'b1 ##0 (temp & ~res_mask) == '0;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("result wider than resolution");

  property p_conv_gap;
    cnt == '0 && primed |-> gap == (CNT_W+1)'(len_seen - 1'b1);
  endproperty
  a_conv_gap: assert property (p_conv_gap) else $error("conversion ended early");

  property p_load;
    $rose(loaded) |-> res == {stored_resolution_hi, stored_resolution_lo}
      && fq == {stored_queue_sel_hi, stored_queue_sel_lo};
  endproperty
  a_load: assert property (p_load) else $error("stored settings not loaded");

  property p_load_alarm;
    $rose(loaded) |-> alarm_active_level == stored_active_level && mode == stored_behaviour_select;
  endproperty
  a_load_alarm: assert property (p_load_alarm) else $error("alarm settings not loaded");

  property p_clear_count;
    fresh && !fault |=> fcount == '0;
  endproperty
  a_clear_count: assert property (p_clear_count) else $error("fault count not cleared");

  property p_inc_count;
    fresh && fault && fcount != FCOUNT_MAX |=> fcount == 3'($past(fcount) + 3'h1);
  endproperty
  a_inc_count: assert property (p_inc_count) else $error("fault count not advanced");

  property p_cmp_set;
    fresh && !mode && hi && 3'(fcount + 3'h1) >= need |=> act ##1 alarm_out == alarm_active_level;
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("comparator alarm not raised");

  property p_int_clear;
    mode && rd_ev && !fresh |=> !act;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("interrupt alarm not cleared");

  property p_level;
    loaded |-> alarm_out == (act ~^ alarm_active_level);
  endproperty
  a_level: assert property (p_level) else $error("alarm level wrong");

  property p_snapshot;
    !lk.hold && $past(!lk.hold) |-> $stable(lk.rd_word);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("read word moved in frame");
endmodule // temp_sensor_alarm_logic
